/* File: logic/ffo_pkg.sv */
// shared constants and types for the fifo flag offset block
package ffo_pkg;

    localparam int OFS_W = 12;
    localparam int CNT_W = 13;
    localparam int SYNC_W = 20;

    // offset value after reset, in words
    localparam logic [11:0] OFS_RESET = 12'h07F;
    // depth in standard and fall-through timing
    localparam logic [12:0] DEPTH_STD = 13'h1000;
    localparam logic [12:0] DEPTH_FT = 13'h1001;

    // bit positions inside the synchronised pin vector
    localparam int PIN_WCLK = 0;
    localparam int PIN_RCLK = 1;
    localparam int PIN_WSTB = 2;
    localparam int PIN_RSTB = 3;
    localparam int PIN_LOAD = 4;
    localparam int PIN_FL = 5;
    localparam int PIN_RXI = 6;
    localparam int PIN_WXI = 7;
    localparam int PIN_DATA = 8;

    // register stages for the boundary flags
    localparam logic [1:0] BUF_SINGLE = 2'h1;
    localparam logic [1:0] BUF_DOUBLE = 2'h2;
    localparam logic [1:0] BUF_TRIPLE = 2'h3;

    typedef enum logic [1:0] {
        FFO_SEL_EMPTY = 2'b01,
        FFO_SEL_FULL = 2'b10
    } ffo_sel_e;

endpackage

/* File: logic/ffo_pin_if.sv */
// carrier for the synchronised pin levels
`timescale 1ns/1ps
interface ffo_pin_if;
    import ffo_pkg::*;
    logic [SYNC_W-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

/* File: logic/ffo_pin_sync.sv */
// three-stage synchroniser with agreement filter for all input pins
`timescale 1ns/1ps
module ffo_pin_sync (
    input wire logic sys_clk,
    input wire logic [ffo_pkg::SYNC_W-1:0] pins,
    ffo_pin_if.src sync
);
    import ffo_pkg::*;

    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] stage3;
    logic [SYNC_W-1:0] stable;

    always_ff @(posedge sys_clk) begin
        stage1 <= pins;
        stage2 <= stage1;
        stage3 <= stage2;
    end

    // a bit only moves once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (stage2[i] == stage3[i]) begin
                    stable[i] <= stage3[i];
                end
            end
        end
    endgenerate

    assign sync.level = stable;
endmodule

/* File: logic/ffo_flag_buf.sv */
// boundary flag register pipeline with selectable stage count
`timescale 1ns/1ps
module ffo_flag_buf (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic adv,
    input wire logic raw,
    input wire logic [1:0] depth,
    output logic flag
);
    import ffo_pkg::*;

    logic [2:0] pipe;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pipe <= 3'h7;
        end else if (adv) begin
            pipe <= {pipe[1:0], raw};
        end
    end

    // more stages trade latency for freedom from metastable boundaries
    assign flag = (depth == BUF_TRIPLE) ? pipe[2] :
                  (depth == BUF_DOUBLE) ? pipe[1] : pipe[0];
endmodule

/* File: logic/ffo_top.sv */
// flag offset loading, readback and reset-time configuration
//
// Function
// - first load write edge stores data low bits into almost-empty offset.
// - next consecutive load write edge stores into almost-full offset.
// - third load edge writes almost-empty again; loads alternate.
// - raising load select resumes normal access; sequence continues later.
// - load read edges show almost-empty offset, then almost-full offset.
// - offset readback only in standard timing, never in fall-through.
// - async almost-empty falls on read edge, rises on write edge.
// - async almost-full falls on write edge, rises on read edge.
// - sync almost-empty changes only on read port edges.
// - sync almost-full changes only on write port edges.
// - timing and partial flag mode latched from straps during reset.
// - straps 001/101 give fall-through, triple buffered empty, double buffered full.
// - straps 000, 011 async, 100 sync: standard, single buffered.
// - straps 010 async, 110 sync: standard, double buffered.
// - straps 111 give standard, single buffered, asynchronous partial.
// - buffering applies only to empty and full boundary flags.
// - each extra buffer stage adds one port clock of flag delay.
// - both offsets reset to 127 words.
`timescale 1ns/1ps
module ffo_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic write_port_clock,
    input wire logic read_port_clock,
    input wire logic write_strobe_low,
    input wire logic read_strobe_low,
    input wire logic offset_load_select,
    input wire logic [ffo_pkg::OFS_W-1:0] data_in_low_bits,
    input wire logic first_load_select,
    input wire logic read_chain_in,
    input wire logic write_chain_in,
    output logic [ffo_pkg::OFS_W-1:0] data_out_low_bits,
    output logic almost_empty_flag,
    output logic almost_full_flag,
    output logic empty_flag,
    output logic full_flag,
    output logic fall_through_timing
);
    import ffo_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    ffo_pin_if pin_bus ();

    ffo_pin_sync u_sync (
        .sys_clk(sys_clk),
        .pins({data_in_low_bits, write_chain_in, read_chain_in,
               first_load_select, offset_load_select, read_strobe_low,
               write_strobe_low, read_port_clock, write_port_clock}),
        .sync(pin_bus.src)
    );

    wire [SYNC_W-1:0] lvl = pin_bus.level;

    // ------------------------------------------------------------
    // port clock events
    // ------------------------------------------------------------
    // a port clock is only an oversampled level: it must stay high
    // and low for two sys_clk each, or two of its edges merge
    logic wclk_prev;
    logic rclk_prev;

    always_ff @(posedge sys_clk) begin
        wclk_prev <= lvl[PIN_WCLK];
        rclk_prev <= lvl[PIN_RCLK];
    end

    wire w_rise = lvl[PIN_WCLK] & ~wclk_prev;
    wire r_rise = lvl[PIN_RCLK] & ~rclk_prev;
    wire loading = ~lvl[PIN_LOAD];
    // strobes and data pass the same three stages as the port clocks,
    // so each edge is qualified by the levels that stood with it
    wire w_act = w_rise & ~lvl[PIN_WSTB];
    wire r_act = r_rise & ~lvl[PIN_RSTB];
    wire [OFS_W-1:0] din = lvl[PIN_DATA +: OFS_W];

    // ------------------------------------------------------------
    // configuration at reset
    // ------------------------------------------------------------
    logic cfg_ft;
    logic cfg_sync;
    logic [1:0] cfg_ebuf;
    logic [1:0] cfg_fbuf;

    wire [2:0] straps = {lvl[PIN_FL], lvl[PIN_RXI], lvl[PIN_WXI]};
    // strap patterns as first-load, read chain, write chain;
    // 000, 011 and 111 need no wire of their own, they take the
    // standard, single buffered, asynchronous defaults
    wire strap_001 = (straps == 3'h1);
    wire strap_010 = (straps == 3'h2);
    wire strap_100 = (straps == 3'h4);
    wire strap_101 = (straps == 3'h5);
    wire strap_110 = (straps == 3'h6);
    wire strap_ft = strap_001 | strap_101;
    // partial flags sync only for 100, 101, 110
    wire strap_sync = strap_100 | strap_101 | strap_110;
    wire strap_dbl = strap_010 | strap_110;
    wire [1:0] strap_ebuf = strap_ft ? BUF_TRIPLE :
                            (strap_dbl ? BUF_DOUBLE : BUF_SINGLE);
    wire [1:0] strap_fbuf = (strap_ft | strap_dbl) ? BUF_DOUBLE :
                            BUF_SINGLE;

    // caught while reset is held
    // every reset cycle samples them again, so the last one wins;
    // a strap moved outside reset waits for the next reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfg_ft <= strap_ft;
            cfg_sync <= strap_sync;
            cfg_ebuf <= strap_ebuf;
            cfg_fbuf <= strap_fbuf;
        end
    end

    // ------------------------------------------------------------
    // offset registers and access sequencing
    // ------------------------------------------------------------
    logic [OFS_W-1:0] almost_empty_threshold;
    logic [OFS_W-1:0] almost_full_threshold;
    ffo_sel_e load_ptr;
    ffo_sel_e read_ptr;

    wire do_load = w_act & loading;
    wire do_rdback = r_act & loading & ~cfg_ft;
    wire [OFS_W-1:0] rdback_val = (read_ptr == FFO_SEL_EMPTY) ?
                                  almost_empty_threshold :
                                  almost_full_threshold;
    wire ffo_sel_e next_load_ptr = (load_ptr == FFO_SEL_EMPTY) ?
                                   FFO_SEL_FULL : FFO_SEL_EMPTY;
    wire ffo_sel_e next_read_ptr = (read_ptr == FFO_SEL_EMPTY) ?
                                   FFO_SEL_FULL : FFO_SEL_EMPTY;

    wire load_ae = do_load & (load_ptr == FFO_SEL_EMPTY);
    wire load_af = do_load & (load_ptr == FFO_SEL_FULL);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almost_empty_threshold <= OFS_RESET;
        end else if (load_ae) begin
            almost_empty_threshold <= din;
        end
    end

    // a new offset moves the partial flags at their next port edge
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almost_full_threshold <= OFS_RESET;
        end else if (load_af) begin
            almost_full_threshold <= din;
        end
    end

    // pointers reset to empty offset, kept across load exits
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            load_ptr <= FFO_SEL_EMPTY;
        end else if (do_load) begin
            load_ptr <= next_load_ptr;
        end
    end

    // readback keeps its own place, so loads and reads may interleave
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            read_ptr <= FFO_SEL_EMPTY;
        end else if (do_rdback) begin
            read_ptr <= next_read_ptr;
        end
    end

    // readback onto the low output bits
    // the value read stays on the pins until the next readback
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            data_out_low_bits <= 12'h000;
        end else if (do_rdback) begin
            data_out_low_bits <= rdback_val;
        end
    end

    // ------------------------------------------------------------
    // occupancy
    // ------------------------------------------------------------
    // no memory array here: only the count is kept, to drive the flags
    logic [CNT_W-1:0] count;
    // fall-through adds the output register to the depth
    wire [CNT_W-1:0] depth = cfg_ft ? DEPTH_FT : DEPTH_STD;
    wire is_full = (count == depth);
    wire is_empty = (count == 13'h0000);
    // strobes during loading leave occupancy alone
    // writes at full and reads at empty are dropped, not queued
    wire wr_word = w_act & ~loading & ~is_full;
    wire rd_word = r_act & ~loading & ~is_empty;
    // a write and a read in one cycle leave the count as it is
    wire [CNT_W-1:0] next_count = (wr_word & ~rd_word) ? count + 13'h0001 :
                                  (rd_word & ~wr_word) ? count - 13'h0001 :
                                  count;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count <= 13'h0000;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // partial flags
    // ------------------------------------------------------------
    // thresholds follow the live offset registers
    // fall-through counts one more word before almost-empty clears
    wire [CNT_W-1:0] ae_lim = {1'b0, almost_empty_threshold} +
                              {12'h000, cfg_ft};
    wire [CNT_W-1:0] af_lim = depth - {1'b0, almost_full_threshold};
    wire ae_low = (next_count <= ae_lim);
    wire af_low = (next_count >= af_lim);

    // almost-empty: async drop on read, rise on write
    // a read and a write edge in one cycle: the read edge wins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almost_empty_flag <= 1'b0;
        end else if (cfg_sync) begin
            if (r_rise) begin
                almost_empty_flag <= ~ae_low;
            end
        end else if (r_rise && ae_low) begin
            almost_empty_flag <= 1'b0;
        end else if (w_rise && !ae_low) begin
            almost_empty_flag <= 1'b1;
        end
    end

    // almost-full: async drop on write, rise on read
    // a read and a write edge in one cycle: the write edge wins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            almost_full_flag <= 1'b1;
        end else if (cfg_sync) begin
            if (w_rise) begin
                almost_full_flag <= ~af_low;
            end
        end else if (w_rise && af_low) begin
            almost_full_flag <= 1'b0;
        end else if (r_rise && !af_low) begin
            almost_full_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // boundary flags
    // ------------------------------------------------------------
    logic empty_buf;
    logic full_buf;

    // only the boundary flags pass the stage pipeline
    // empty advances on read edges, full on write edges; both pipes
    // reset to 1 and hold their boundary until edges shift it out
    ffo_flag_buf u_ebuf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .adv(r_rise),
        .raw(next_count == 13'h0000),
        .depth(cfg_ebuf),
        .flag(empty_buf)
    );

    ffo_flag_buf u_fbuf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .adv(w_rise),
        .raw(next_count == depth),
        .depth(cfg_fbuf),
        .flag(full_buf)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // fall-through shows ready flags (high = empty/full), standard
    // shows active-low empty and full
    wire next_empty_flag = cfg_ft ? empty_buf : ~empty_buf;
    wire next_full_flag = cfg_ft ? full_buf : ~full_buf;

    // every pin leaves a flip-flop, so no decode glitch reaches the host
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            empty_flag <= 1'b0;
            full_flag <= 1'b1;
            fall_through_timing <= 1'b0;
        end else begin
            empty_flag <= next_empty_flag;
            full_flag <= next_full_flag;
            fall_through_timing <= cfg_ft;
        end
    end
endmodule

/* File: verification/ffo_top_properties.sv */
// port assertions for the flag offset block
`timescale 1ns/1ps
module ffo_top_properties (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic write_port_clock,
    input wire logic read_port_clock,
    input wire logic write_strobe_low,
    input wire logic read_strobe_low,
    input wire logic offset_load_select,
    input wire logic [ffo_pkg::OFS_W-1:0] data_in_low_bits,
    input wire logic first_load_select,
    input wire logic read_chain_in,
    input wire logic write_chain_in,
    input wire logic [ffo_pkg::OFS_W-1:0] data_out_low_bits,
    input wire logic almost_empty_flag,
    input wire logic almost_full_flag,
    input wire logic empty_flag,
    input wire logic full_flag,
    input wire logic fall_through_timing
);
    import ffo_pkg::*;
    // cycles since a raw port clock rise; the pins take up to 6 to act
    logic [3:0] wr_age, rd_age;
    wire sync_pf = first_load_select && !(read_chain_in && write_chain_in);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge sys_clk) begin
        wr_age <= !nrst ? 4'hF : $rose(write_port_clock) ? 4'h0
            : wr_age + {3'h0, wr_age != 4'hF};
        rd_age <= !nrst ? 4'hF : $rose(read_port_clock) ? 4'h0
            : rd_age + {3'h0, rd_age != 4'hF};
    end
    property p_rst_vals;
        $rose(nrst) |-> data_out_low_bits == 12'h000 && !almost_empty_flag
            && almost_full_flag && !empty_flag && full_flag;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset vals");
    property p_mode;
        $past(nrst) |-> fall_through_timing ==
            (!read_chain_in && write_chain_in);
    endproperty
    a_mode: assert property (p_mode) else $error("timing mode");
    property p_ft_hold;
        fall_through_timing && $past(fall_through_timing)
            |-> $stable(data_out_low_bits);
    endproperty
    a_ft_hold: assert property (p_ft_hold) else $error("ft readback");
    property p_dout;
        $past(nrst) && !$stable(data_out_low_bits) |-> rd_age <= 4'h8;
    endproperty
    a_dout: assert property (p_dout) else $error("readback cause");
    property p_ae_fall;
        $fell(almost_empty_flag) |-> rd_age <= 4'h8;
    endproperty
    a_ae_fall: assert property (p_ae_fall) else $error("ae fall");
    property p_ae_rise;
        $rose(almost_empty_flag) |-> (sync_pf ? rd_age : wr_age) <= 4'h8;
    endproperty
    a_ae_rise: assert property (p_ae_rise) else $error("ae rise");
    property p_af_fall;
        $fell(almost_full_flag) |-> wr_age <= 4'h8;
    endproperty
    a_af_fall: assert property (p_af_fall) else $error("af fall");
    property p_af_rise;
        $rose(almost_full_flag) |-> (sync_pf ? wr_age : rd_age) <= 4'h8;
    endproperty
    a_af_rise: assert property (p_af_rise) else $error("af rise");
endmodule
bind ffo_top ffo_top_properties i_props (.*);

/* File: verification/ffo_host.sv */
// host model driving the write and read port pins
`timescale 1ns/1ps
module ffo_host (
    input wire logic sys_clk,
    output logic write_port_clock,
    output logic read_port_clock,
    output logic write_strobe_low,
    output logic read_strobe_low,
    output logic offset_load_select,
    output logic [ffo_pkg::OFS_W-1:0] data_in_low_bits
);
    import ffo_pkg::*;
    initial data_in_low_bits = 12'h000;
    initial idle();
    task automatic idle;
        write_port_clock = 1'b0;
        read_port_clock = 1'b0;
        write_strobe_low = 1'b1;
        read_strobe_low = 1'b1;
        offset_load_select = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
    // pins lead the edge by two cycles so the synchroniser sees them first
    task automatic pulse(input logic wr, input logic ld, input logic stb,
            input logic [OFS_W-1:0] d);
        @(negedge sys_clk);
        offset_load_select = ld;
        write_strobe_low = wr ? stb : 1'b1;
        read_strobe_low = wr ? 1'b1 : stb;
        data_in_low_bits = d;
        repeat (2) @(negedge sys_clk);
        write_port_clock = wr;
        read_port_clock = !wr;
        repeat (4) @(negedge sys_clk);
        write_port_clock = 1'b0;
        read_port_clock = 1'b0;
        repeat (4) @(negedge sys_clk);
        data_in_low_bits = ~d;
    endtask
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the flag offset block
`timescale 1ns/1ps
module tb_top;
    import ffo_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic first_load_select = 1'b0, read_chain_in = 1'b0;
    logic write_chain_in = 1'b0;
    logic write_port_clock, read_port_clock, write_strobe_low;
    logic read_strobe_low, offset_load_select;
    logic [OFS_W-1:0] data_in_low_bits, data_out_low_bits;
    logic almost_empty_flag, almost_full_flag, empty_flag, full_flag;
    logic fall_through_timing;
    int err_total = 0;
    int samples_checked = 0;
    ffo_top i_dut (.*);
    ffo_host i_host (.*);
    always #10 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [11:0] seen,
            input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(negedge sys_clk);
        nrst = 1'b0;
        {first_load_select, read_chain_in, write_chain_in} = s;
        i_host.idle();
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic t_straps;
        logic ft;
        logic [OFS_W-1:0] rb_exp;
        for (int s = 0; s < 8; s++) begin
            ft = (s == 1) || (s == 5);
            rb_exp = ft ? 12'h000 : OFS_RESET;
            do_reset(3'(s));
            check("mode", 12'(fall_through_timing), 12'(ft));
            check("empty", 12'(empty_flag), 12'(ft));
            i_host.pulse(1'b0, 1'b0, 1'b0, 12'h000);
            check("rdback", data_out_low_bits, rb_exp);
        end
    endtask
    task automatic t_load;
        do_reset(3'h0);
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'hA5C);
        i_host.pulse(1'b0, 1'b0, 1'b0, 12'h000);
        check("ae 1st", data_out_low_bits, 12'hA5C);
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'h3C1);
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'h5E7);
        i_host.pulse(1'b0, 1'b0, 1'b0, 12'h000);
        check("af 2nd", data_out_low_bits, 12'h3C1);
        i_host.pulse(1'b0, 1'b0, 1'b0, 12'h000);
        check("ae 3rd", data_out_low_bits, 12'h5E7);
        i_host.idle();
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'hFFE);
        i_host.pulse(1'b0, 1'b0, 1'b0, 12'h000);
        check("af resume", data_out_low_bits, 12'hFFE);
    endtask
    // thresholds 0 and 4095 make one word cross both partial flags
    task automatic t_flags(input logic sync);
        do_reset({sync, 2'h0});
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'h000);
        i_host.pulse(1'b1, 1'b0, 1'b0, 12'hFFF);
        i_host.idle();
        i_host.pulse(1'b1, 1'b1, 1'b0, 12'h123);
        check("ae wr", 12'(almost_empty_flag), 12'(!sync));
        check("af wr", 12'(almost_full_flag), 12'h000);
        i_host.pulse(1'b0, 1'b1, 1'b1, 12'h000);
        check("ae rclk", 12'(almost_empty_flag), 12'h001);
        check("empty", 12'(empty_flag), 12'h001);
        i_host.pulse(1'b0, 1'b1, 1'b0, 12'h000);
        check("ae rd", 12'(almost_empty_flag), 12'h000);
        check("af rd", 12'(almost_full_flag), 12'(!sync));
        i_host.pulse(1'b1, 1'b1, 1'b1, 12'h000);
        check("af wclk", 12'(almost_full_flag), 12'h001);
        check("full", 12'(full_flag), 12'h001);
    endtask
    // one word stored, then n idle read edges clear the empty pipe
    task automatic t_buf(input logic [2:0] s, input int n,
            input logic ft);
        do_reset(s);
        i_host.pulse(1'b1, 1'b1, 1'b0, 12'h055);
        for (int k = 1; k <= n; k++) begin
            i_host.pulse(1'b0, 1'b1, 1'b1, 12'h000);
            check("empty buf", 12'(empty_flag), 12'(ft ^ (k == n)));
        end
    endtask
    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        t_straps();
        t_load();
        t_flags(1'b0);
        t_flags(1'b1);
        // double buffered empty in standard timing
        t_buf(3'h2, 2, 1'b0);
        // triple buffered ready flag in fall-through timing
        t_buf(3'h1, 3, 1'b1);
        complete_run();
    end
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
endmodule
